/* File: src/irq_vec_pkg.sv */
// shared constants and carriers for the vectored interrupt priority unit
// assumes a single 40 MHz clock domain and a classic wishbone host
`default_nettype none
package irq_vec_pkg;
	// ==========================================================
	// sizes
	localparam int NUM_SRC = 26;
	localparam int NUM_GRP = 4;
	localparam int GRP_SLOTS = 6;
	localparam int SRC_ALARM = 24;
	localparam int SRC_CONV = 25;
	// ==========================================================
	// register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_PEND = 8'h04;
	localparam logic [7:0] OFF_LINE = 8'h08;
	localparam logic [7:0] OFF_MASK = 8'h0c;
	localparam logic [7:0] OFF_IRQ_CLR = 8'h10;
	localparam logic [7:0] OFF_FIQ_CLR = 8'h14;
	localparam logic [7:0] OFF_SUBPEND = 8'h18;
	localparam logic [7:0] OFF_SLAVE_ORD = 8'h1c;
	localparam logic [7:0] OFF_MASTER_ORD = 8'h20;
	localparam logic [7:0] OFF_RR_MODE = 8'h24;
	localparam logic [7:0] OFF_ACTIVE = 8'h28;
	// ==========================================================
	// fields and reset values
	localparam int CTRL_VEC_BIT = 2;
	localparam int CTRL_IRQ_BIT = 1;
	localparam int CTRL_FIQ_BIT = 0;
	localparam int GLOBAL_MASK_BIT = 26;
	localparam logic [2:0] CTRL_RST = 3'h7;
	localparam logic [26:0] MASK_RST = 27'h7ff_ffff;
	localparam logic [7:0] ORDER_RST = 8'he4;
	// ==========================================================
	// vector generation
	localparam logic [31:0] IRQ_VECTOR_ADDR = 32'h0000_0018;
	localparam logic [31:0] BRANCH_BASE = 32'hea00_0000;
	localparam logic [31:0] PIPE_OFFSET = 32'h0000_0008;
	localparam logic [31:0] TARGET_BASE = 32'h0000_0020;
	localparam logic [31:0] GROUP_STRIDE = 32'h0000_0020;
	localparam logic [31:0] SLOT_STRIDE = 32'h0000_0004;
	localparam logic [31:0] ALARM_TARGET = 32'h0000_00a0;
	localparam logic [31:0] CONV_TARGET = 32'h0000_00c0;
	// ==========================================================
	// carriers
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [7:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} wb_req_s;
	typedef struct packed {
		logic ext_req_0;
		logic ext_req_1;
		logic ext_req_2;
		logic ext_req_3;
		logic [3:0] ext_req_upper;
		logic tick_req;
		logic general_dma0_req;
		logic general_dma1_req;
		logic bridge_dma0_req;
		logic bridge_dma1_req;
		logic watchdog_req;
		logic [1:0] serial_error_inputs;
		logic timer0_req;
		logic timer1_req;
		logic timer2_req;
		logic timer3_req;
		logic timer4_req;
		logic timer5_req;
		logic serial0_rx_req;
		logic serial1_rx_req;
		logic two_wire_bus_req;
		logic sync_serial_req;
		logic serial0_tx_req;
		logic serial1_tx_req;
		logic alarm_req;
		logic converter_done_req;
	} src_in_s;
endpackage
`default_nettype wire

/* File: src/vectored_irq_priority_unit.sv */
// vectored irq priority unit: pending capture, two-level arbitration,
// branch word supply on the irq vector fetch, wishbone register slave
// assumes requests synchronous to clk and a core fetch strobe on clk
//
// Functional notes
// - 26 arbitrated sources; upper external pins and serial errors OR-merged
// - priority logic serves irq-routed sources, used in vectored mode
// - five units: one master over four slave winners plus two sources
// - fixed group and slot membership of sources 0 to 23; alarm and converter-done feed the master
// - each slave: four programmable slots above two fixed slots
// - any unmasked fiq-routed request beats every irq-routed request while fiq is enabled
// - sources in different groups rank by group priority only
// - sources in one group rank by slot priority in that group
// - programmable slots by programmed order or round robin; first fixed wins
// - groups by order or round robin, above alarm then converter-done
// - in vectored mode drive branch word on fetch of the irq vector
// - word is base plus (target minus fetch address minus 8) over 4
// - external request 0 branches to 0x20 with the bare base word
// - each source has its own target address
// - four-bit sub-pending for merged pins, cleared by writing one
// - masked sources still pend but are not served; global mask too
// - control bit 2 selects vectoring, 0 vectored, reset value 1
// - pending is read-only, cleared by writing one to a clear register
// - fiq never gets a hardware branch word
`default_nettype none
module vectored_irq_priority_unit
	import irq_vec_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// interrupt sources
	input wire src_in_s src,
	// wishbone slave
	input wire wb_req_s wb,
	output logic wb_ack,
	output logic [31:0] wb_dat_o,
	// core vector fetch
	input wire logic fetch_valid,
	input wire logic [31:0] fetch_addr,
	output logic vec_drive,
	output logic [31:0] vec_word,
	// request lines to the core
	output logic irq,
	output logic fiq
);
	// ==========================================================
	// functions
	// highest ranked requesting slot; order[1:0] holds the top slot
	function automatic logic [1:0] pick4(input logic [3:0] req,
		input logic [7:0] order);
		logic [1:0] res;
		res = order[1:0];
		for (int i = 3; i >= 0; i--)
		begin
			if (req[order[2*i+:2]])
				res = order[2*i+:2];
		end
		return res;
	endfunction

	// rotation: slot after last is top, last itself is bottom
	function automatic logic [7:0] rr_order(input logic [1:0] last);
		return {last, 2'(last + 2'd3), 2'(last + 2'd2), 2'(last + 2'd1)};
	endfunction

	function automatic logic [2:0] pick6(input logic [5:0] req,
		input logic [7:0] order);
		if (|req[3:0])
			return {1'b0, pick4(req[3:0], order)};
		else if (req[4])
			return 3'd4;
		else
			return 3'd5;
	endfunction

	function automatic logic [31:0] target_of(input logic [4:0] s);
		logic [31:0] g;
		logic [31:0] k;
		g = 32'(s) / GRP_SLOTS;
		k = 32'(s) % GRP_SLOTS;
		if (s == 5'(SRC_ALARM))
			return ALARM_TARGET;
		else if (s == 5'(SRC_CONV))
			return CONV_TARGET;
		else
			return TARGET_BASE + g * GROUP_STRIDE + k * SLOT_STRIDE;
	endfunction

	// source 0 gives exactly the base word
	function automatic logic [31:0] branch_of(input logic [4:0] s);
		return BRANCH_BASE
			+ ((target_of(s) - IRQ_VECTOR_ADDR - PIPE_OFFSET) >> 2);
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] sel);
		logic [31:0] m;
		m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
		return (old & ~m) | (nw & m);
	endfunction

	// ==========================================================
	// state
	logic [2:0] ctrl_r;
	logic [25:0] pend_r;
	logic [25:0] line_r;
	logic [26:0] mask_r;
	logic [3:0] subpend_r;
	logic [31:0] slave_ord_r;
	logic [7:0] master_ord_r;
	logic [4:0] rr_mode_r;
	logic [7:0] slave_last_r;
	logic [1:0] master_last_r;
	logic [4:0] active_r;
	logic active_vld_r;
	logic [25:0] prev_raw_r;
	logic [3:0] prev_upper_r;
	logic [4:0] win_r;
	logic win_vld_r;
	logic [31:0] vec_word_r;
	logic irq_r;
	logic fiq_r;
	logic ack_r;
	logic [31:0] dat_r;

	logic [25:0] raw;
	logic [25:0] ev;
	logic [25:0] elig;
	logic [25:0] fiq_elig;
	logic [3:0] up_rise;
	logic [3:0] gvld;
	logic [11:0] gslot;
	logic [1:0] grp;
	logic [4:0] win;
	logic win_vld;
	logic wr;
	logic wb_take;

	// ==========================================================
	// source merging and edge capture
	always_comb
	begin
		raw[0] = src.ext_req_0;
		raw[1] = src.ext_req_1;
		raw[2] = src.ext_req_2;
		raw[3] = src.ext_req_3;
		raw[4] = |src.ext_req_upper;
		raw[5] = src.tick_req;
		raw[6] = src.general_dma0_req;
		raw[7] = src.general_dma1_req;
		raw[8] = src.bridge_dma0_req;
		raw[9] = src.bridge_dma1_req;
		raw[10] = src.watchdog_req;
		raw[11] = |src.serial_error_inputs;
		raw[12] = src.timer0_req;
		raw[13] = src.timer1_req;
		raw[14] = src.timer2_req;
		raw[15] = src.timer3_req;
		raw[16] = src.timer4_req;
		raw[17] = src.timer5_req;
		raw[18] = src.serial0_rx_req;
		raw[19] = src.serial1_rx_req;
		raw[20] = src.two_wire_bus_req;
		raw[21] = src.sync_serial_req;
		raw[22] = src.serial0_tx_req;
		raw[23] = src.serial1_tx_req;
		raw[24] = src.alarm_req;
		raw[25] = src.converter_done_req;
		up_rise = src.ext_req_upper & ~prev_upper_r;
		ev = raw & ~prev_raw_r;
		// a second pin rising while another still holds the OR high
		ev[4] = |up_rise;
	end

	// previous levels for rising-edge detection
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			prev_raw_r <= '0;
			prev_upper_r <= '0;
		end
		else
		begin
			prev_raw_r <= raw;
			prev_upper_r <= src.ext_req_upper;
		end
	end

	// ==========================================================
	// wishbone slave: one wait state, ack pulses for one cycle
	assign wb_take = wb.cyc & wb.stb & ~ack_r;
	assign wr = wb_take & wb.we;

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			ack_r <= 1'b0;
			dat_r <= '0;
		end
		else
		begin
			ack_r <= wb_take;
			if (wb_take & ~wb.we)
			begin
				unique case (wb.adr)
					OFF_CTRL: dat_r <= {29'd0, ctrl_r};
					OFF_PEND: dat_r <= {6'd0, pend_r};
					OFF_LINE: dat_r <= {6'd0, line_r};
					OFF_MASK: dat_r <= {5'd0, mask_r};
					OFF_SUBPEND: dat_r <= {28'd0, subpend_r};
					OFF_SLAVE_ORD: dat_r <= slave_ord_r;
					OFF_MASTER_ORD: dat_r <= {24'd0, master_ord_r};
					OFF_RR_MODE: dat_r <= {27'd0, rr_mode_r};
					OFF_ACTIVE: dat_r <= {26'd0, active_vld_r, active_r};
					default: dat_r <= '0; // clear regs and holes read zero
				endcase
			end
		end
	end

	assign wb_ack = ack_r;
	assign wb_dat_o = dat_r;

	// ==========================================================
	// configuration registers
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			ctrl_r <= CTRL_RST;
			line_r <= '0;
			mask_r <= MASK_RST;
			slave_ord_r <= {4{ORDER_RST}};
			master_ord_r <= ORDER_RST;
			rr_mode_r <= '0;
		end
		else if (wr)
		begin
			unique case (wb.adr)
				OFF_CTRL: ctrl_r <= 3'(merge({29'd0, ctrl_r}, wb.dat, wb.sel));
				OFF_LINE: line_r <= 26'(merge({6'd0, line_r}, wb.dat, wb.sel));
				OFF_MASK: mask_r <= 27'(merge({5'd0, mask_r}, wb.dat, wb.sel));
				OFF_SLAVE_ORD: slave_ord_r <= merge(slave_ord_r, wb.dat, wb.sel);
				OFF_MASTER_ORD:
					master_ord_r <= 8'(merge({24'd0, master_ord_r}, wb.dat,
						wb.sel));
				OFF_RR_MODE:
					rr_mode_r <= 5'(merge({27'd0, rr_mode_r}, wb.dat, wb.sel));
				default: ;
			endcase
		end
	end

	// ==========================================================
	// pending and sub-pending: a new event beats a same-cycle clear
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			pend_r <= '0;
			subpend_r <= '0;
		end
		else
		begin
			// masked sources still pend
			pend_r <= (pend_r & ~(wr && (wb.adr == OFF_IRQ_CLR
				|| wb.adr == OFF_FIQ_CLR) ? wb.dat[25:0] : 26'd0))
				| ev;
			subpend_r <= (subpend_r & ~(wr && wb.adr == OFF_SUBPEND ?
				wb.dat[3:0] : 4'd0)) | up_rise;
		end
	end

	// ==========================================================
	// arbitration, irq-routed and unmasked sources only
	assign elig = pend_r & ~line_r & ~mask_r[25:0]
		& {26{~mask_r[GLOBAL_MASK_BIT]}};
	assign fiq_elig = pend_r & line_r & ~mask_r[25:0]
		& {26{~mask_r[GLOBAL_MASK_BIT]}};

	// four slave units
	always_comb
	begin
		for (int g = 0; g < NUM_GRP; g++)
		begin
			gvld[g] = |elig[g*GRP_SLOTS+:GRP_SLOTS];
			gslot[g*3+:3] = pick6(elig[g*GRP_SLOTS+:GRP_SLOTS],
				rr_mode_r[g] ? rr_order(slave_last_r[g*2+:2])
				: slave_ord_r[g*8+:8]);
		end
	end

	// master unit: groups first, then alarm, then converter-done
	always_comb
	begin
		grp = pick4(gvld, rr_mode_r[NUM_GRP] ? rr_order(master_last_r)
			: master_ord_r);
		win_vld = |elig;
		if (|gvld)
			win = 5'(grp) * 5'd6 + {2'd0, gslot[grp*3+:3]};
		else if (elig[SRC_ALARM])
			win = 5'(SRC_ALARM);
		else
			win = 5'(SRC_CONV);
	end

	// winner and its branch word held in flops for the data bus
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			win_r <= '0;
			win_vld_r <= 1'b0;
			vec_word_r <= '0;
		end
		else
		begin
			win_r <= win;
			win_vld_r <= win_vld;
			vec_word_r <= branch_of(win);
		end
	end

	// ==========================================================
	// request lines: fiq pre-empts irq
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			irq_r <= 1'b0;
			fiq_r <= 1'b0;
		end
		else
		begin
			fiq_r <= (|fiq_elig) & ~ctrl_r[CTRL_FIQ_BIT];
			irq_r <= win_vld & ~ctrl_r[CTRL_IRQ_BIT]
				& ~((|fiq_elig) & ~ctrl_r[CTRL_FIQ_BIT]);
		end
	end

	assign irq = irq_r;
	assign fiq = fiq_r;

	// ==========================================================
	// vector supply: only the irq vector, only in vectored mode;
	// the fiq vector address never matches, so fiq is never steered
	assign vec_drive = fetch_valid && fetch_addr == IRQ_VECTOR_ADDR
		&& !ctrl_r[CTRL_VEC_BIT] && irq_r && win_vld_r;
	assign vec_word = vec_word_r;

	// grant bookkeeping: rotation and the serviced-source report
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			slave_last_r <= {4{2'd3}};
			master_last_r <= 2'd3;
			active_r <= '0;
			active_vld_r <= 1'b0;
		end
		else if (vec_drive)
		begin
			active_r <= win_r;
			active_vld_r <= 1'b1;
			if (win_r < 5'(SRC_ALARM))
			begin
				master_last_r <= 2'(win_r / 5'd6);
				if (5'(win_r % 5'd6) < 5'd4)
					slave_last_r[2*(win_r/5'd6)+:2] <= 2'(win_r % 5'd6);
			end
		end
	end
endmodule
`default_nettype wire

/* File: verification/core_model.sv */
// behavioural processor core: fetches the irq vector on request
// assumes the bench pulses go when an irq entry is wanted
`default_nettype none
module core_model
	import irq_vec_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// bench control
	input wire logic go,
	input wire logic [1:0] lag,
	// unit side
	input wire logic irq,
	input wire logic vec_drive,
	input wire logic [31:0] vec_word,
	output logic fetch_valid,
	output logic [31:0] fetch_addr,
	// result of the vector fetch
	output logic got_v,
	output logic [31:0] got_w
);
	timeunit 1ns;
	timeprecision 1ps;
	logic pend_r = 1'b0;
	logic take_r = 1'b0;
	logic [1:0] wait_r = 2'h0;
	logic [31:0] pc_r = 32'h0000_0100;
	// other fetches run on half the cycles (pc bit 3 set) so the vector decode is exercised
	assign fetch_valid = take_r | pc_r[3];
	assign fetch_addr = take_r ? IRQ_VECTOR_ADDR : pc_r;
	// enters the vector only while irq is up; fiq never takes this path
	always_ff @(posedge clk)
		if (srst)
		begin
			pend_r <= 1'b0;
			take_r <= 1'b0;
			got_v <= 1'b0;
			pc_r <= 32'h0000_0100;
		end
		else
		begin
			pc_r <= pc_r + 32'h0000_0004;
			take_r <= 1'b0;
			got_v <= take_r;
			got_w <= vec_drive ? vec_word : 32'h0000_0000; // memory reads 0
			if (go)
			begin
				pend_r <= 1'b1;
				wait_r <= lag;
			end
			else if (wait_r != 2'h0)
				wait_r <= wait_r - 2'h1;
			else if (pend_r && irq)
			begin
				pend_r <= 1'b0;
				take_r <= 1'b1;
			end
		end
endmodule
`default_nettype wire

/* File: verification/irq_unit_props.sv */
// port checks for the vectored irq priority unit
// assumes the unit's package and a single clock domain
`default_nettype none
module irq_unit_props
	import irq_vec_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// register bus
	input wire wb_req_s wb,
	input wire logic wb_ack,
	// core side
	input wire logic fetch_valid,
	input wire logic [31:0] fetch_addr,
	input wire logic vec_drive,
	input wire logic [31:0] vec_word,
	input wire logic irq,
	input wire logic fiq
);
	timeunit 1ns;
	timeprecision 1ps;
	logic wr_seen_r;
	// ====================
	// helper
	// set on any write attempt: before one, vectoring must stay off
	always_ff @(posedge clk)
		if (srst)
			wr_seen_r <= 1'b0;
		else if (wb.cyc && wb.stb && wb.we)
			wr_seen_r <= 1'b1;
	default clocking @(posedge clk);
	endclocking
	default disable iff (srst);
	sequence take_q;
		wb.cyc && wb.stb && !wb_ack;
	endsequence
	sequence ack_q;
		wb_ack ##1 !wb_ack;
	endsequence
	// ====================
	// checks
	AST_ACK_ONE: assert property (take_q |=> ack_q)
		else $error("bus access not answered by a one-cycle ack");
	AST_ACK_CAUSE: assert property (wb_ack |-> $past(wb.stb) && $past(wb.cyc))
		else $error("ack without a request");
	AST_FIQ_FIRST: assert property (fiq |-> !irq)
		else $error("irq raised beside fiq");
	AST_VEC_FETCH: assert property (vec_drive |-> fetch_valid &&
		fetch_addr == IRQ_VECTOR_ADDR)
		else $error("branch word driven off the irq vector fetch");
	AST_VEC_FORM: assert property (vec_drive |->
		vec_word[31:6] == 26'h3a8_0000 && (vec_word[5:0] == 6'h20 ||
		vec_word[5:0] == 6'h28 || (!vec_word[5] && vec_word[2:0] < 3'h6)))
		else $error("branch word has no valid target");
	AST_VEC_OFF: assert property (!wr_seen_r |-> !vec_drive)
		else $error("vectoring active with reset control");
	AST_RST_QUIET: assert property ($fell(srst) |-> !irq && !fiq &&
		!wb_ack && !vec_drive && vec_word == 32'h0000_0000)
		else $error("outputs not quiet after reset");
	AST_IRQ_HOLD: assert property ($fell(irq) |-> fiq || $past(wb.we) ||
		$past(wb.we, 2) || $past(wb.we, 3))
		else $error("irq dropped with no clear or fiq");
endmodule
bind vectored_irq_priority_unit irq_unit_props irq_unit_props_inst (
	.clk(clk), .srst(srst), .wb(wb), .wb_ack(wb_ack),
	.fetch_valid(fetch_valid), .fetch_addr(fetch_addr),
	.vec_drive(vec_drive), .vec_word(vec_word), .irq(irq), .fiq(fiq)
);
`default_nettype wire

/* File: verification/tb_vectored_irq_priority_unit.sv */
// bench for the vectored irq priority unit over wishbone and a core model
// assumes the unit's package and core_model
`default_nettype none
module tb_vectored_irq_priority_unit
	import irq_vec_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, srst = 1'b1, go = 1'b0;
	logic [1:0] lag = 2'h0;
	src_in_s src = '0;
	wb_req_s wb = '0;
	logic wb_ack, vec_drive, irq, fiq, fetch_valid, got_v;
	logic [31:0] wb_dat_o, vec_word, fetch_addr, got_w;
	logic [31:0] rnd = 32'h0000_143f;
	logic [31:0] rd_q[$], vec_q[$];
	int fail_count = 0, checks_done = 0, k = 0;
	int pairs[6][3] = '{'{12, 3, 3}, '{4, 1, 1}, '{5, 4, 4},
		'{24, 25, 24}, '{23, 24, 23}, '{2, 0, 0}};
	// ====================
	// clock
	initial
		forever #12.5 clk = ~clk;
	vectored_irq_priority_unit vectored_irq_priority_unit_inst (
		.clk(clk), .srst(srst), .src(src), .wb(wb), .wb_ack(wb_ack),
		.wb_dat_o(wb_dat_o), .fetch_valid(fetch_valid),
		.fetch_addr(fetch_addr), .vec_drive(vec_drive),
		.vec_word(vec_word), .irq(irq), .fiq(fiq));
	core_model core_model_inst (
		.clk(clk), .srst(srst), .go(go), .lag(lag), .irq(irq),
		.vec_drive(vec_drive), .vec_word(vec_word),
		.fetch_valid(fetch_valid), .fetch_addr(fetch_addr),
		.got_v(got_v), .got_w(got_w));
	// ====================
	// helpers
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// bit of a source in the struct; merged inputs pick lane k
	function automatic int pos(input int i);
		if (i < 4)
			return 29 - i;
		if (i == 4)
			return 22 + k;
		if (i == 11)
			return 14 + k[0];
		if (i < 11)
			return 26 - i;
		return 25 - i;
	endfunction
	function automatic logic [31:0] word(input int w);
		logic [31:0] t;
		t = TARGET_BASE + GROUP_STRIDE * (w / 6) + SLOT_STRIDE * (w % 6);
		if (w == SRC_ALARM)
			t = ALARM_TARGET;
		if (w == SRC_CONV)
			t = CONV_TARGET;
		return BRANCH_BASE + ((t - IRQ_VECTOR_ADDR - PIPE_OFFSET) >> 2);
	endfunction
	task automatic chk(input string nm, input logic [31:0] s, e);
		checks_done++;
		if (s !== e)
		begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic results;
		if (fail_count == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic guard(input int n);
		if (n < 40)
			return;
		fail_count++;
		results;
	endtask
	// one classic cycle; for reads d is the expected data
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		if (!w)
			rd_q.push_back(d);
		rnd = lfsr(rnd);
		wb <= '{1'b1, 1'b1, w, a, 4'hf, w ? d : rnd};
		@(posedge clk);
		while (wb_ack !== 1'b1 && n++ < 40)
			@(posedge clk);
		guard(n);
		wb <= '0;
		@(posedge clk);
	endtask
	// rising edge on two sources, then the documented irq latency
	task automatic fire(input int a, b);
		src <= src_in_s'((30'h1 << pos(a)) | (30'h1 << pos(b)));
		@(posedge clk);
		src <= '0;
		repeat (4) @(posedge clk);
	endtask
	task automatic arb(input int a, b, w, input logic v);
		int n;
		n = 0;
		rnd = lfsr(rnd);
		k = int'(rnd[1:0]);
		lag <= rnd[3:2];
		fire(a, b);
		chk("irq", irq, 1);
		vec_q.push_back(v ? word(w) : 32'h0000_0000);
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		while (got_v !== 1'b1 && n++ < 40)
			@(posedge clk);
		guard(n);
		if (v)
			bus(0, OFF_ACTIVE, 32'h0000_0020 | w);
		if (a == 4 && b == 4)
		begin
			bus(0, OFF_SUBPEND, 32'h1 << k);
			bus(1, OFF_SUBPEND, 32'h1 << k);
			bus(0, OFF_SUBPEND, 32'h0000_0000);
		end
		bus(1, a[0] ? OFF_FIQ_CLR : OFF_IRQ_CLR, (32'h1 << a) | (32'h1 << b));
	endtask
	// ====================
	// result watchers
	always @(posedge clk)
		if (wb_ack === 1'b1 && wb.we === 1'b0 && rd_q.size() > 0)
			chk("wb_dat_o", wb_dat_o, rd_q.pop_front());
	always @(posedge clk)
		if (got_v === 1'b1 && vec_q.size() > 0)
			chk("vec_word", got_w, vec_q.pop_front());
	// ====================
	// main sequence
	initial
	begin
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		bus(0, OFF_CTRL, 32'h0000_0007);
		bus(0, OFF_MASK, 32'h07ff_ffff);
		bus(0, OFF_LINE, 32'h0000_0000);
		bus(0, OFF_SLAVE_ORD, 32'he4e4_e4e4);
		bus(0, OFF_MASTER_ORD, 32'h0000_00e4);
		bus(1, 8'h3c, 32'hffff_ffff);
		bus(0, 8'h3c, 32'h0000_0000);
		fire(12, 12);
		chk("irq", irq, 0);
		bus(1, OFF_PEND, 32'hffff_ffff);
		bus(0, OFF_PEND, 32'h0000_1000);
		bus(1, OFF_FIQ_CLR, 32'h0000_1000);
		bus(0, OFF_PEND, 32'h0000_0000);
		bus(1, OFF_MASK, 32'h0400_0000);
		bus(1, OFF_CTRL, 32'h0000_0000);
		fire(0, 0);
		chk("irq", irq, 0);
		bus(1, OFF_MASK, 32'h0000_0000);
		repeat (2) @(posedge clk);
		chk("irq", irq, 1);
		bus(1, OFF_IRQ_CLR, 32'h0000_0001);
		for (int i = 0; i < NUM_SRC; i++)
			arb(i, i, i, 1'b1);
		for (int i = 0; i < 6; i++)
			arb(pairs[i][0], pairs[i][1], pairs[i][2], 1'b1);
		bus(1, OFF_SLAVE_ORD, 32'he4e4_e41b);
		arb(0, 3, 3, 1'b1);
		bus(1, OFF_MASTER_ORD, 32'h0000_001b);
		arb(0, 18, 18, 1'b1);
		bus(1, OFF_SLAVE_ORD, 32'he4e4_e4e4);
		bus(1, OFF_MASTER_ORD, 32'h0000_00e4);
		bus(1, OFF_RR_MODE, 32'h0000_0001);
		arb(0, 0, 0, 1'b1);
		arb(0, 1, 1, 1'b1);
		bus(1, OFF_RR_MODE, 32'h0000_0010);
		arb(0, 0, 0, 1'b1);
		arb(0, 12, 12, 1'b1);
		bus(1, OFF_RR_MODE, 32'h0000_0000);
		bus(1, OFF_LINE, 32'h0000_1000);
		fire(12, 0);
		chk("fiq", fiq, 1);
		chk("irq", irq, 0);
		bus(1, OFF_IRQ_CLR, 32'h0000_1001);
		bus(1, OFF_LINE, 32'h0000_0000);
		bus(1, OFF_CTRL, 32'h0000_0006);
		fire(1, 1);
		chk("irq", irq, 0);
		bus(1, OFF_CTRL, 32'h0000_0004);
		arb(1, 1, 1, 1'b0);
		repeat (4) @(posedge clk);
		chk("queues", rd_q.size() + vec_q.size(), 0);
		results;
	end
endmodule
`default_nettype wire
